// ---- rtl/scp_prescaler.sv ----
// System clock prescaler with protected control register and oscillator trim
`timescale 1ns/1ps
module scp_prescaler
	import scp_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_reset,
	input wire logic i_divide_by_eight_fuse,
	input wire logic [7:0] i_factory_trim,
	input wire logic [SCP_ADDR_W-1:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	output logic [7:0] o_oscillator_trim,
	output logic o_cpu_clk_en,
	output logic o_flash_clk_en,
	output logic o_io_clk_en,
	output logic o_adc_clk_en
);
	logic [7:0] trim_reg;
	logic [3:0] division_select_reg;
	logic [3:0] active_shift_reg;
	logic [2:0] window_cnt_reg;
	logic divide_change_enable;
	logic ctrl_wr;
	logic unlock_wr;
	logic select_wr;
	logic tick;
	logic apply;
	logic tick_reg;
	logic [7:0] rdata_reg;
	scp_switch_e state_reg;

	assign ctrl_wr = i_wr && (i_addr == SCP_ADDR_CTRL);
	// change-enable only with other bits zero
	assign unlock_wr = ctrl_wr && (i_wdata == SCP_UNLOCK_VALUE);
	// any select value taken when unlocked
	assign select_wr = ctrl_wr && divide_change_enable && !i_wdata[SCP_CTRL_CE_BIT];
	assign divide_change_enable = (window_cnt_reg != 3'h0);

	// window closes after four cycles or select
	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
		begin
			window_cnt_reg <= 3'h0;
		end
		else if (select_wr)
		begin
			window_cnt_reg <= 3'h0;
		end
		else if (unlock_wr && !divide_change_enable)
		begin
			window_cnt_reg <= SCP_WINDOW_CYCLES;
		end
		else if (divide_change_enable)
		begin
			window_cnt_reg <= window_cnt_reg - 3'h1;
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
		begin
			division_select_reg <= i_divide_by_eight_fuse ? SCP_SEL_RESET_DIV8 : SCP_SEL_RESET_PLAIN;
		end
		else if (select_wr)
		begin
			division_select_reg <= i_wdata[SCP_CTRL_SEL_MSB:0];
		end
	end

	// new setting waits for an old-rate edge
	assign apply = (state_reg == SCP_ST_PENDING) && tick;

	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
		begin
			state_reg <= SCP_ST_STEADY;
		end
		else
		begin
			case (state_reg)
				SCP_ST_STEADY:
				begin
					if (select_wr)
					begin
						state_reg <= SCP_ST_PENDING;
					end
				end
				SCP_ST_PENDING:
				begin
					if (apply && !select_wr)
					begin
						state_reg <= SCP_ST_STEADY;
					end
				end
				default:
				begin
					state_reg <= SCP_ST_STEADY;
				end
			endcase
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
		begin
			active_shift_reg <= scp_sel_to_shift(
				i_divide_by_eight_fuse ? SCP_SEL_RESET_DIV8 : SCP_SEL_RESET_PLAIN);
		end
		else if (apply)
		begin
			active_shift_reg <= scp_sel_to_shift(division_select_reg);
		end
	end

	// restart only at an edge, so periods stay whole
	scp_ratio_counter u_ratio_counter (
		.i_core_clk(i_core_clk),
		.i_reset(i_reset),
		.i_restart(apply),
		.i_shift(active_shift_reg),
		.o_tick(tick)
	);

	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
		begin
			tick_reg <= 1'b0;
		end
		else
		begin
			tick_reg <= tick;
		end
	end

	// one enable shared by all clock domains
	assign o_cpu_clk_en = tick_reg;
	assign o_flash_clk_en = tick_reg;
	assign o_io_clk_en = tick_reg;
	assign o_adc_clk_en = tick_reg;

	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
		begin
			trim_reg <= i_factory_trim;
		end
		else if (i_wr && (i_addr == SCP_ADDR_TRIM))
		begin
			trim_reg <= i_wdata;
		end
	end

	// low seven bits tune within range
	assign o_oscillator_trim = trim_reg;

	// control layout; bits 6 to 4 zero
	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
		begin
			rdata_reg <= 8'h00;
		end
		else if (i_rd && (i_addr == SCP_ADDR_TRIM))
		begin
			rdata_reg <= trim_reg;
		end
		else if (i_rd && (i_addr == SCP_ADDR_CTRL))
		begin
			rdata_reg <= {divide_change_enable, 3'h0, division_select_reg};
		end
		else
		begin
			rdata_reg <= 8'h00;
		end
	end

	assign o_rdata = rdata_reg;

	// Checking helpers: spacing between enable pulses
	logic [SCP_GAP_W-1:0] gap_reg;
	logic [3:0] tick_shift_reg;
	logic seen_tick_reg;

	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
		begin
			gap_reg <= '0;
			tick_shift_reg <= 4'h0;
			seen_tick_reg <= 1'b0;
		end
		else
		begin
			gap_reg <= tick_reg ? 9'h0 : gap_reg + 9'h1;
			if (tick)
			begin
				tick_shift_reg <= active_shift_reg;
			end
			if (tick_reg)
			begin
				seen_tick_reg <= 1'b1;
			end
		end
	end

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_reset);

	a_unlock_opens: assert property (
		unlock_wr && !divide_change_enable |=> divide_change_enable)
		else $error("unlock write did not open the window");

	a_bad_unlock_ignored: assert property (
		ctrl_wr && i_wdata[SCP_CTRL_CE_BIT] && (i_wdata[6:0] != 7'h0) && !divide_change_enable
		|=> !divide_change_enable)
		else $error("change-enable set by a write with other bits set");

	a_window_four_cycles: assert property (
		divide_change_enable [*4] |=> !divide_change_enable)
		else $error("change window stayed open past four cycles");

	a_window_full_length: assert property (
		unlock_wr && !divide_change_enable ##1 !select_wr [*3] |=> divide_change_enable)
		else $error("change window closed early");

	a_select_closes: assert property (
		select_wr |=> !divide_change_enable && division_select_reg == $past(i_wdata[3:0]))
		else $error("select write did not store value or close window");

	a_locked_select: assert property (
		ctrl_wr && !divide_change_enable |=> division_select_reg == $past(division_select_reg))
		else $error("select changed without unlock");

	a_reset_select: assert property (
		disable iff (1'b0)
		$fell(i_reset) |-> division_select_reg ==
			($past(i_divide_by_eight_fuse) ? SCP_SEL_RESET_DIV8 : SCP_SEL_RESET_PLAIN))
		else $error("reset select does not follow fuse");

	a_reserved_zero: assert property (
		i_rd && i_addr == SCP_ADDR_CTRL |=> o_rdata[6:4] == 3'h0)
		else $error("reserved control bits read nonzero");

	a_switch_bound: assert property (
		select_wr |=> ##[0:256] tick ##1 active_shift_reg == scp_sel_to_shift(division_select_reg))
		else $error("new division not active within one old period");

	a_whole_periods: assert property (
		tick_reg && seen_tick_reg |-> gap_reg == 9'((16'h1 << tick_shift_reg) - 16'h1))
		else $error("clock period differs from old or new setting");

	a_trim_write: assert property (
		i_wr && i_addr == SCP_ADDR_TRIM |=> o_oscillator_trim == $past(i_wdata))
		else $error("trim write not stored");

	a_reset_trim: assert property (
		disable iff (1'b0)
		$fell(i_reset) |-> o_oscillator_trim == $past(i_factory_trim))
		else $error("trim not loaded with factory value at reset");

	a_trim_held: assert property (
		!(i_wr && i_addr == SCP_ADDR_TRIM) |=> $stable(o_oscillator_trim))
		else $error("trim changed without a trim write");

	a_window_rewrite: assert property (
		unlock_wr && divide_change_enable |=> window_cnt_reg == $past(window_cnt_reg) - 3'h1)
		else $error("rewrite inside window restarted or cleared it");

	a_read_idle_zero: assert property (
		!i_rd |=> o_rdata == 8'h00)
		else $error("read data not zero outside read answer");

	c_unlock_then_select: cover property (unlock_wr ##[1:4] select_wr);
	c_switch_applied: cover property (state_reg == SCP_ST_PENDING ##1 apply);
	c_window_timeout: cover property (unlock_wr ##1 divide_change_enable [*4] ##1 1'b1);
	c_reserved_code: cover property (select_wr && i_wdata[3:0] > SCP_SEL_MAX_VALID);
endmodule : scp_prescaler

// ---- rtl/scp_pkg.sv ----
// Constants shared by the system clock prescaler design files
package scp_pkg;
	localparam int SCP_ADDR_W = 2;
	localparam int SCP_CNT_W = 8;
	localparam int SCP_GAP_W = 9;
	localparam logic [1:0] SCP_ADDR_TRIM = 2'h0;
	localparam logic [1:0] SCP_ADDR_CTRL = 2'h1;
	localparam int SCP_CTRL_CE_BIT = 7;
	localparam int SCP_CTRL_SEL_MSB = 3;
	localparam logic [3:0] SCP_SEL_RESET_PLAIN = 4'h0;
	localparam logic [3:0] SCP_SEL_RESET_DIV8 = 4'h3;
	localparam logic [3:0] SCP_SEL_MAX_VALID = 4'h8;
	localparam logic [2:0] SCP_WINDOW_CYCLES = 3'h4;
	localparam logic [7:0] SCP_UNLOCK_VALUE = 8'h80;

	typedef enum logic {
		SCP_ST_STEADY = 1'b0,
		SCP_ST_PENDING = 1'b1
	} scp_switch_e;

	// Reserved select codes run at the slowest valid ratio
	function automatic logic [3:0] scp_sel_to_shift(input logic [3:0] sel);
		scp_sel_to_shift = (sel > SCP_SEL_MAX_VALID) ? SCP_SEL_MAX_VALID : sel;
	endfunction : scp_sel_to_shift
endpackage : scp_pkg

// ---- rtl/scp_ratio_counter.sv ----
// Power-of-two ratio counter running on the undivided master clock
`timescale 1ns/1ps
module scp_ratio_counter
	import scp_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_reset,
	input wire logic i_restart,
	input wire logic [3:0] i_shift,
	output logic o_tick
);
	logic [SCP_CNT_W-1:0] count_reg;
	logic [SCP_CNT_W-1:0] mask;

	assign mask = 8'((16'h1 << i_shift) - 16'h1);
	assign o_tick = ((count_reg & mask) == mask);

	always_ff @(posedge i_core_clk)
	begin
		if (i_reset || i_restart)
		begin
			count_reg <= '0;
		end
		else
		begin
			count_reg <= count_reg + 8'h1;
		end
	end
endmodule : scp_ratio_counter

// ---- bench/scp_prescaler_tb.sv ----
// Self-checking bench for the system clock prescaler
`timescale 1ns/1ps
module scp_prescaler_tb
	import scp_pkg::*;
;
	logic clk;
	logic rst;
	logic fuse;
	logic [7:0] ftrim;
	logic [SCP_ADDR_W-1:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;
	logic [7:0] trim;
	logic en_cpu;
	logic en_fl;
	logic en_io;
	logic en_adc;
	int errors;
	int tests_run;
	int g0;
	int g1;
	int old_p;
	int new_p;

	scp_prescaler i_dut (
		.i_core_clk(clk),
		.i_reset(rst),
		.i_divide_by_eight_fuse(fuse),
		.i_factory_trim(ftrim),
		.i_addr(addr),
		.i_wdata(wdata),
		.i_wr(wr),
		.i_rd(rd),
		.o_rdata(rdata),
		.o_oscillator_trim(trim),
		.o_cpu_clk_en(en_cpu),
		.o_flash_clk_en(en_fl),
		.o_io_clk_en(en_io),
		.o_adc_clk_en(en_adc)
	);

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		tests_run++;
		if (seen !== exp)
		begin
			errors++;
			$display("wrong value %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : chk

	task automatic end_sim;
		if (errors == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim

	task automatic bus_wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : bus_wr

	task automatic bus_rd(input logic [1:0] a, input logic [7:0] e, input string w);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(16'(rdata), 16'(e), w);
	endtask : bus_rd

	task automatic do_reset(input logic f, input logic [7:0] t);
		@(posedge clk);
		rst <= 1'b1;
		fuse <= f;
		ftrim <= t;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
	endtask : do_reset

	// Cycles up to and including the next enable pulse
	task automatic gap(output int n);
		n = 0;
		do
		begin
			@(posedge clk);
			#1;
			n++;
		end
		while (en_cpu !== 1'b1 && n < 600);
		chk(16'({en_fl, en_io, en_adc}), 16'h7, "domain enables");
	endtask : gap

	initial
	begin
		repeat (20000) @(posedge clk);
		errors++;
		end_sim();
	end

	initial
	begin
		rst = 1'b1;
		fuse = 1'b0;
		ftrim = 8'h00;
		addr = '0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		errors = 0;
		tests_run = 0;
		do_reset(1'b1, 8'h5a);
		bus_rd(SCP_ADDR_CTRL, 8'h03, "ctrl fuse reset");
		bus_rd(SCP_ADDR_TRIM, 8'h5a, "trim reset");
		gap(g0);
		gap(g0);
		chk(16'(g0), 16'h8, "fuse period");
		do_reset(1'b0, 8'ha3);
		bus_rd(SCP_ADDR_CTRL, 8'h00, "ctrl plain reset");
		bus_rd(SCP_ADDR_TRIM, 8'ha3, "trim reset");
		// trim set with no flash writes
		bus_wr(SCP_ADDR_TRIM, 8'h7f);
		bus_rd(SCP_ADDR_TRIM, 8'h7f, "trim write");
		chk(16'(trim), 16'h7f, "trim output");
		bus_wr(2'h2, 8'hff);
		bus_rd(2'h2, 8'h00, "unmapped");
		bus_rd(SCP_ADDR_TRIM, 8'h7f, "unmapped write");
		// Locked write and malformed unlock are both ignored
		bus_wr(SCP_ADDR_CTRL, 8'h05);
		bus_rd(SCP_ADDR_CTRL, 8'h00, "locked write");
		bus_wr(SCP_ADDR_CTRL, 8'h81);
		bus_wr(SCP_ADDR_CTRL, 8'h05);
		bus_rd(SCP_ADDR_CTRL, 8'h00, "bad unlock");
		// Rewrite inside window must not extend it
		bus_wr(SCP_ADDR_CTRL, 8'h80);
		bus_rd(SCP_ADDR_CTRL, 8'h80, "window open");
		bus_wr(SCP_ADDR_CTRL, 8'h80);
		bus_rd(SCP_ADDR_CTRL, 8'h00, "window timeout");
		bus_wr(SCP_ADDR_CTRL, 8'h05);
		bus_rd(SCP_ADDR_CTRL, 8'h00, "late select");
		// Early rewrite must not close the window either
		bus_wr(SCP_ADDR_CTRL, 8'h80);
		bus_wr(SCP_ADDR_CTRL, 8'h80);
		bus_wr(SCP_ADDR_CTRL, 8'h02);
		bus_rd(SCP_ADDR_CTRL, 8'h02, "rewrite keeps window");
		bus_wr(SCP_ADDR_CTRL, 8'h80);
		bus_wr(SCP_ADDR_CTRL, 8'h76);
		bus_rd(SCP_ADDR_CTRL, 8'h06, "select write");
		bus_wr(SCP_ADDR_CTRL, 8'h80);
		bus_wr(SCP_ADDR_CTRL, 8'h00);
		old_p = 64;
		for (int k = 0; k < 10; k++)
		begin
			new_p = (k > 8) ? 256 : (1 << k);
			bus_wr(SCP_ADDR_CTRL, 8'h80);
			bus_wr(SCP_ADDR_CTRL, 8'(k));
			gap(g0);
			chk(16'(g0 <= old_p + 1), 16'h1, "switch delay");
			gap(g1);
			chk(16'(g1), 16'(new_p), "first new period");
			gap(g1);
			chk(16'(g1), 16'(new_p), "period");
			bus_rd(SCP_ADDR_CTRL, 8'(k), "select readback");
			old_p = new_p;
		end
		end_sim();
	end
endmodule : scp_prescaler_tb
